// ### design/pbpu_top.sv
// port b pull-up / analog-select configuration with apb register access
`timescale 1ns/10ps
module pbpu_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pbpu_pkg::ADDR_W-1:0] paddr,
  input wire logic [pbpu_pkg::BUS_W-1:0] pwdata,
  output logic [pbpu_pkg::BUS_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [pbpu_pkg::DATA_W-1:0] pin_in,
  output logic [pbpu_pkg::DATA_W-1:0] pin_out,
  output logic [pbpu_pkg::DATA_W-1:0] pin_oe_n,
  output logic [pbpu_pkg::DATA_W-1:0] pullup_on,
  output logic [pbpu_pkg::DATA_W-1:0] digital_in_en,
  output logic [pbpu_pkg::DATA_W-1:0] ioc_qualify
);
  logic [pbpu_pkg::DATA_W-1:0] port_b_pullup_enable;
  logic [pbpu_pkg::DATA_W-1:0] port_b_analog_select;
  logic [pbpu_pkg::DATA_W-1:0] option_control;
  logic [pbpu_pkg::DATA_W-1:0] port_b_pin_data;
  logic [pbpu_pkg::DATA_W-1:0] port_b_direction;
  logic [pbpu_pkg::DATA_W-1:0] next_port_b_pullup_enable;
  logic [pbpu_pkg::DATA_W-1:0] next_port_b_analog_select;
  logic [pbpu_pkg::DATA_W-1:0] next_option_control;
  logic [pbpu_pkg::DATA_W-1:0] next_port_b_pin_data;
  logic [pbpu_pkg::DATA_W-1:0] next_port_b_direction;

  logic [pbpu_pkg::BUS_W-1:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic wr_en;
  logic addr_hit;
  logic [pbpu_pkg::DATA_W-1:0] rd_byte;
  logic [pbpu_pkg::DATA_W-1:0] pin_read;

  pbpu_gate_if gif ();

  // gating runs on the next register values so the flopped pin controls
  // change on the very edge that stores a write
  assign gif.pullup_enable = next_port_b_pullup_enable;
  assign gif.analog_select = next_port_b_analog_select;
  assign gif.direction = next_port_b_direction;
  assign gif.pin_data = next_port_b_pin_data;
  assign gif.global_pullup_control = next_option_control[pbpu_pkg::POS_GLOBAL_PULLUP];

  pbpu_gate u_gate (
    .g(gif.gate)
  );

  // register file
  always_comb begin
    wr_en = psel & penable & pready & pwrite;
    next_port_b_pullup_enable = port_b_pullup_enable;
    next_port_b_analog_select = port_b_analog_select;
    next_option_control = option_control;
    next_port_b_pin_data = port_b_pin_data;
    next_port_b_direction = port_b_direction;
    if (wr_en) begin
      case (paddr)
        pbpu_pkg::OFS_PULLUP_ENABLE: begin
          next_port_b_pullup_enable = pwdata[pbpu_pkg::DATA_W-1:0] & pbpu_pkg::MASK_PULLUP; // [R1] [R2]
        end
        pbpu_pkg::OFS_ANALOG_SELECT: begin
          next_port_b_analog_select = pwdata[pbpu_pkg::DATA_W-1:0] & pbpu_pkg::MASK_ANALOG; // [R4] [R2]
        end
        pbpu_pkg::OFS_OPTION_CONTROL: begin
          next_option_control = pwdata[pbpu_pkg::DATA_W-1:0] & pbpu_pkg::MASK_OPTION;
        end
        pbpu_pkg::OFS_PIN_DATA: begin
          next_port_b_pin_data = pwdata[pbpu_pkg::DATA_W-1:0] & pbpu_pkg::MASK_PORT;
        end
        pbpu_pkg::OFS_DIRECTION: begin
          next_port_b_direction = pwdata[pbpu_pkg::DATA_W-1:0] & pbpu_pkg::MASK_PORT;
        end
        default: begin
          next_port_b_direction = port_b_direction;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_b_pullup_enable <= pbpu_pkg::RST_PULLUP;
      port_b_analog_select <= pbpu_pkg::RST_ANALOG; // [R9]
      option_control <= pbpu_pkg::RST_OPTION; // [R10]
      port_b_pin_data <= pbpu_pkg::RST_PIN_DATA;
      port_b_direction <= pbpu_pkg::RST_DIRECTION;
    end else if (ce) begin
      port_b_pullup_enable <= next_port_b_pullup_enable;
      port_b_analog_select <= next_port_b_analog_select;
      option_control <= next_option_control;
      port_b_pin_data <= next_port_b_pin_data;
      port_b_direction <= next_port_b_direction;
    end
  end

  // apb slave: one wait-free access phase, read data captured in setup
  always_comb begin
    // an analog pin reads zero whatever its level
    pin_read = pin_in & ~port_b_analog_select & pbpu_pkg::MASK_PORT; // [R7]
    addr_hit = 1'b1;
    case (paddr)
      pbpu_pkg::OFS_PULLUP_ENABLE: begin
        rd_byte = port_b_pullup_enable & pbpu_pkg::MASK_PULLUP; // [R2]
      end
      pbpu_pkg::OFS_ANALOG_SELECT: begin
        rd_byte = port_b_analog_select & pbpu_pkg::MASK_ANALOG; // [R2]
      end
      pbpu_pkg::OFS_OPTION_CONTROL: begin
        rd_byte = option_control;
      end
      pbpu_pkg::OFS_PIN_DATA: begin
        rd_byte = pin_read;
      end
      pbpu_pkg::OFS_DIRECTION: begin
        rd_byte = port_b_direction;
      end
      default: begin
        rd_byte = 8'h00;
        addr_hit = 1'b0;
      end
    endcase
    next_pready = psel & ~penable;
    next_pslverr = psel & ~penable & ~addr_hit;
    next_prdata = prdata;
    if (psel & ~penable) begin
      next_prdata = {24'h000000, rd_byte};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // pin controls, flopped from the gated next values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pullup_on <= 8'h00;
      digital_in_en <= 8'h00;
      ioc_qualify <= 8'h00;
      pin_out <= 8'h00;
      pin_oe_n <= 8'hFF;
    end else if (ce) begin
      pullup_on <= gif.pullup_on; // [R3] [R8] [R11]
      digital_in_en <= gif.digital_in_en; // [R5] [R11]
      ioc_qualify <= gif.digital_in_en; // [R5]
      // analog pins stay driven if software leaves them as outputs
      pin_out <= gif.drive_out;
      pin_oe_n <= gif.drive_oe_n;
    end
  end
endmodule

// ### design/pbpu_pkg.sv
// constants for the port b pull-up and analog-select block
// Operation
// [R1] writable pull-up enable on pins 7-4, 1
// [R2] unimplemented bits read back as zero
// [R3] pull-up needs global, input, enable, digital
// [R4] analog-select bits on pins 6-4, 1
// [R5] analog pin: no digital input, pull-up, change-qualify
// [R6] software keeps analog pins set as inputs
// [R7] analog pin reads zero in port data
// [R8] output pin never gets its pull-up
// [R9] analog-select bits reset to analog
// [R10] reset global control disables all pull-ups
// [R11] write reaches pin gating next cycle
package pbpu_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned BUS_W = 32;

  localparam logic [ADDR_W-1:0] OFS_PULLUP_ENABLE = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_ANALOG_SELECT = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_OPTION_CONTROL = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_PIN_DATA = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_DIRECTION = 8'h10;

  localparam logic [DATA_W-1:0] MASK_PULLUP = 8'hF2;
  localparam logic [DATA_W-1:0] MASK_ANALOG = 8'h72;
  localparam logic [DATA_W-1:0] MASK_PORT = 8'hF3;
  localparam logic [DATA_W-1:0] MASK_OPTION = 8'hFF;

  localparam logic [DATA_W-1:0] RST_PULLUP = 8'hF2;
  localparam logic [DATA_W-1:0] RST_ANALOG = 8'h72;
  localparam logic [DATA_W-1:0] RST_OPTION = 8'hFF;
  localparam logic [DATA_W-1:0] RST_PIN_DATA = 8'h00;
  localparam logic [DATA_W-1:0] RST_DIRECTION = 8'hF3;

  localparam int unsigned POS_GLOBAL_PULLUP = 7;
  localparam int unsigned POS_OPEN_DRAIN = 0;
endpackage

// ### design/pbpu_gate_if.sv
// configuration bits out to the pin gating and gated results back
`timescale 1ns/10ps
interface pbpu_gate_if;
  logic [pbpu_pkg::DATA_W-1:0] pullup_enable;
  logic [pbpu_pkg::DATA_W-1:0] analog_select;
  logic [pbpu_pkg::DATA_W-1:0] direction;
  logic [pbpu_pkg::DATA_W-1:0] pin_data;
  logic global_pullup_control;
  logic [pbpu_pkg::DATA_W-1:0] pullup_on;
  logic [pbpu_pkg::DATA_W-1:0] digital_in_en;
  logic [pbpu_pkg::DATA_W-1:0] drive_out;
  logic [pbpu_pkg::DATA_W-1:0] drive_oe_n;

  modport regs (
    output pullup_enable, analog_select, direction, pin_data, global_pullup_control,
    input pullup_on, digital_in_en, drive_out, drive_oe_n
  );
  modport gate (
    input pullup_enable, analog_select, direction, pin_data, global_pullup_control,
    output pullup_on, digital_in_en, drive_out, drive_oe_n
  );
endinterface

// ### design/pbpu_gate.sv
// per-pin pull-up, digital input and driver gating
`timescale 1ns/10ps
module pbpu_gate (
  pbpu_gate_if.gate g
);
  logic [pbpu_pkg::DATA_W-1:0] analog;

  always_comb begin
    analog = g.analog_select & pbpu_pkg::MASK_ANALOG;
    // a set global bit means pull-ups off
    g.pullup_on = {pbpu_pkg::DATA_W{~g.global_pullup_control}} // [R3]
                  & g.direction // [R8]
                  & g.pullup_enable & pbpu_pkg::MASK_PULLUP
                  & ~analog; // [R5]
    g.digital_in_en = ~analog & pbpu_pkg::MASK_PORT; // [R5]
    // analog select leaves the output driver alone; direction decides, and on the open-drain pin the pin data too
    g.drive_out = g.pin_data & pbpu_pkg::MASK_PORT;
    g.drive_oe_n = g.direction | ~pbpu_pkg::MASK_PORT;
    // open-drain pin only ever pulls low
    g.drive_out[pbpu_pkg::POS_OPEN_DRAIN] = 1'b0;
    g.drive_oe_n[pbpu_pkg::POS_OPEN_DRAIN] = g.direction[pbpu_pkg::POS_OPEN_DRAIN]
                                             | g.pin_data[pbpu_pkg::POS_OPEN_DRAIN];
  end
endmodule

// ### test/pbpu_top_props.sv
// port-level assertions for the port b pull-up block
`timescale 1ns/10ps
module pbpu_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] pin_in,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe_n,
  input wire logic [7:0] pullup_on,
  input wire logic [7:0] digital_in_en,
  input wire logic [7:0] ioc_qualify
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_PU_UNIMPL: assert property ((pullup_on & 8'h0D) == 8'h00)
    else $error("pull-up on an unimplemented pin");
  AST_PU_OUTPUT: assert property ((pullup_on & ~pin_oe_n) == 8'h00)
    else $error("pull-up on a driven pin");
  AST_PU_ANALOG: assert property ((pullup_on & ~digital_in_en) == 8'h00)
    else $error("pull-up on an analog pin");
  AST_IOC_QUAL: assert property (ioc_qualify == digital_in_en)
    else $error("change qualifier differs from digital input enable");
  AST_DIN_UNIMPL: assert property ((digital_in_en & 8'h0C) == 8'h00)
    else $error("digital input on an unimplemented pin");
  AST_RD_UPPER: assert property (pready && !pwrite |-> prdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  AST_GLOBAL_OFF: assert property (psel && penable && pready && pwrite && ce && pwdata[7]
    && paddr == pbpu_pkg::OFS_OPTION_CONTROL |=> pullup_on == 8'h00) else $error("global control left pull-ups on");
  AST_PIN_READ: assert property (psel && !penable && !pwrite && ce && paddr == pbpu_pkg::OFS_PIN_DATA
    |=> prdata[7:0] == ($past(pin_in) & $past(digital_in_en))) else $error("analog pin read not zero");
endmodule

// ### test/pbpu_top_bench.sv
// self-checking bench for the port b pull-up block
`timescale 1ns/10ps
module pbpu_top_bench;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, pu_chk;
  logic [7:0] paddr, pin_in, pin_out, pin_oe_n, pullup_on, digital_in_en, ioc_qualify, dir, an, pu, opt, v, pd;
  logic [31:0] pwdata, prdata, seed;
  logic [31:0] rd_q[$];
  logic [31:0] pin_q[$];
  logic [7:0] pu_q[$];
  logic err_q[$];
  int mismatches, tests_run;
  pbpu_top dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .pin_in, .pin_out, .pin_oe_n, .pullup_on, .digital_in_en, .ioc_qualify);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction
  task automatic rnd(output logic [7:0] r);
    seed = lfsr(seed);
    r = seed[7:0];
  endtask
  task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_pu(input logic [7:0] got, input logic [7:0] exp);
    cmp_rd({24'h000000, got}, {24'h000000, exp});
  endtask
  task automatic cmp_err(input logic got, input logic exp);
    cmp_rd({31'h00000000, got}, {31'h00000000, exp});
  endtask
  // pin word packs drive enable, driven level, digital input enable and change qualifier
  task automatic cmp_pin(input logic [31:0] got, input logic [31:0] exp);
    cmp_rd(got, exp);
  endtask
  // reads note their expected data; the monitor below compares it when the access completes
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) rd_q.push_back(d);
    err_q.push_back(!(a inside {pbpu_pkg::OFS_PULLUP_ENABLE, pbpu_pkg::OFS_ANALOG_SELECT,
      pbpu_pkg::OFS_OPTION_CONTROL, pbpu_pkg::OFS_PIN_DATA, pbpu_pkg::OFS_DIRECTION}));
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) cmp_rd(prdata, rd_q.pop_front());
    if (psel && penable && pready) cmp_err(pslverr, err_q.pop_front());
    if (pu_chk) cmp_pu(pullup_on, pu_q.pop_front());
    if (pu_chk) cmp_pin({pin_oe_n, pin_out, digital_in_en, ioc_qualify}, pin_q.pop_front());
  end
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    report_and_stop();
  end
  initial begin
    {presetn, ce, psel, penable, pwrite, pu_chk} = 6'h10;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    seed = 32'hC37D1930;
    pin_in = 8'h5B;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, pbpu_pkg::OFS_PULLUP_ENABLE, 32'h000000F2);
    apb(1'b0, pbpu_pkg::OFS_ANALOG_SELECT, 32'h00000072);
    apb(1'b0, pbpu_pkg::OFS_OPTION_CONTROL, 32'h000000FF);
    apb(1'b0, pbpu_pkg::OFS_PIN_DATA, {24'h000000, pin_in & 8'h81});
    apb(1'b0, 8'h14, 32'h00000000);
    apb(1'b1, pbpu_pkg::OFS_PULLUP_ENABLE, 32'hFFFFFFFF);
    apb(1'b0, pbpu_pkg::OFS_PULLUP_ENABLE, 32'h000000F2);
    apb(1'b1, pbpu_pkg::OFS_ANALOG_SELECT, 32'hFFFFFFFF);
    apb(1'b0, pbpu_pkg::OFS_ANALOG_SELECT, 32'h00000072);
    for (int i = 0; i < 16; i++) begin
      rnd(dir);
      rnd(an);
      // software keeps every analog pin an input
      dir = dir | (an & 8'h72);
      rnd(pu);
      rnd(opt);
      rnd(v);
      rnd(pd);
      pin_in <= v;
      apb(1'b1, pbpu_pkg::OFS_DIRECTION, {24'h000000, dir});
      apb(1'b1, pbpu_pkg::OFS_ANALOG_SELECT, {24'h000000, an});
      apb(1'b1, pbpu_pkg::OFS_PULLUP_ENABLE, {24'h000000, pu});
      apb(1'b1, pbpu_pkg::OFS_PIN_DATA, {24'h000000, pd});
      apb(1'b1, pbpu_pkg::OFS_OPTION_CONTROL, {24'h000000, opt});
      // bit 7 has no analog select, so only the implemented select bits gate
      pu_q.push_back((opt[7] ? 8'h00 : 8'hFF) & dir & pu & ~(an & 8'h72) & 8'hF2);
      pin_q.push_back({dir | 8'h0C | {7'h00, pd[0]}, pd & 8'hF2, {2{~(an & 8'h72) & 8'hF3}}});
      pu_chk <= 1'b1;
      @(posedge pclk);
      pu_chk <= 1'b0;
      apb(1'b0, pbpu_pkg::OFS_PIN_DATA, {24'h000000, v & 8'hF3 & ~(an & 8'h72)});
    end
    // second reset in mid-run: registers and pin controls must fall back
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    pu_q.push_back(8'h00);
    pin_q.push_back(32'hFF008181);
    pu_chk <= 1'b1;
    @(posedge pclk);
    pu_chk <= 1'b0;
    apb(1'b0, pbpu_pkg::OFS_ANALOG_SELECT, 32'h00000072);
    apb(1'b0, pbpu_pkg::OFS_OPTION_CONTROL, 32'h000000FF);
    report_and_stop();
  end
endmodule
bind pbpu_top pbpu_props chk (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .pin_in, .pin_out, .pin_oe_n, .pullup_on, .digital_in_en, .ioc_qualify);
